// [rtl/acccs_regs.sv]
// Calibration configuration and status register bank with status pin and
// trigger routing. Assumes a plain register port on CLK and an engine on CLK.
//
// Notes on behaviour
// R1 - Offset reference select at 0 asks the engine to calibrate toward mid-code.
// R2 - Offset reference select at 1 asks the engine to use the spare converter as reference.
// R3 - Software sets the offset reference select only while background calibration is on.
// R4 - Offset averaging depth sits in bits 6:4 of the averaging register and resets to 6.
// R5 - Linearity averaging depth sits in bits 2:0 of the averaging register and resets to 1.
// R6 - The status register is read-only and holds a 3-bit status code in bits 4:2.
// R7 - The halted flag in bit 1 reads 1 once background calibration has stopped.
// R8 - The halted flag returns to 0 as soon as calibration resumes.
// R9 - With background disabled the halted flag sets when foreground finishes or is skipped.
// R10 - The foreground-complete flag in bit 0 reads 1 when foreground finished or was skipped.
// R11 - Software writes reset values into every reserved field.
// R12 - The pin source field routes done, halted, alarm or a constant low to the status pin.
// R13 - The trigger source bit picks the hardware input at 1 and the software bit at 0.
// R14 - The background enable bit resets to 0 and turns background calibration on at 1.
// R15 - Reset restores writable fields to their reset values and clears status flags.
// R16 - Writes to the status register are ignored.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module acccs_regs (
    // Clock and reset.
    input wire logic CLK,
    input wire logic NRST,
    // Register port.
    input wire logic [acccs_pkg::ADDR_W-1:0] ADDR,
    input wire logic [acccs_pkg::DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [acccs_pkg::DATA_W-1:0] RDATA,
    // Calibration engine side.
    input wire acccs_pkg::acccs_engine_t ENGINE,
    input wire logic ALARM,
    output acccs_pkg::acccs_cfg_t CFG,
    output logic CAL_TRIGGER,
    // Pins.
    input wire logic HARDWARE_TRIGGER_INPUT,
    output logic CALIBRATION_STATUS_PIN,
    // Interrupt.
    output logic IRQ
);

    logic [7:0] offset_cal_config;
    logic [7:0] averaging_config;
    logic [7:0] calibration_pin_setup;
    logic [7:0] bg_control;
    logic [7:0] soft_trigger;
    logic foreground_complete_flag;
    logic halted_flag;
    logic [2:0] status_code;
    logic [acccs_pkg::IRQ_W-1:0] irq_status;
    logic [acccs_pkg::IRQ_W-1:0] irq_mask;
    logic [acccs_pkg::IRQ_W-1:0] irq_event;
    logic [2:0] trig_sync;
    logic trig_clean;
    logic alarm_q;
    logic fg_q;
    logic halt_q;
    logic [7:0] next_rdata;
    acccs_pkg::acccs_pin_sel_t pin_sel;

    // Decodes a write strobe at one offset.
    function automatic logic wr_hit(input logic [7:0] a, input logic w, input logic [7:0] ofs);
        wr_hit = w && (a == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Writable configuration
    // ------------------------------------------------------------------

    // Reserved bits are stored as written; software keeps them at reset values.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            offset_cal_config <= acccs_pkg::RST_OFFSET_CAL_CONFIG; // R15
            averaging_config <= acccs_pkg::RST_AVERAGING_CONFIG; // R4
            calibration_pin_setup <= acccs_pkg::RST_CALIBRATION_PIN_SETUP;
            bg_control <= acccs_pkg::RST_BG_CONTROL; // R14
            soft_trigger <= acccs_pkg::RST_SOFT_TRIGGER;
        end else begin
            if (wr_hit(ADDR, WR, acccs_pkg::OFS_OFFSET_CAL_CONFIG)) begin
                offset_cal_config <= WDATA; // R11
            end
            if (wr_hit(ADDR, WR, acccs_pkg::OFS_AVERAGING_CONFIG)) begin
                averaging_config <= WDATA; // R5
            end
            if (wr_hit(ADDR, WR, acccs_pkg::OFS_CALIBRATION_PIN_SETUP)) begin
                calibration_pin_setup <= WDATA;
            end
            if (wr_hit(ADDR, WR, acccs_pkg::OFS_BG_CONTROL)) begin
                bg_control <= WDATA;
            end
            if (wr_hit(ADDR, WR, acccs_pkg::OFS_SOFT_TRIGGER)) begin
                soft_trigger <= WDATA;
            end
        end
    end

    // Settings fed to the engine; reference choice passes straight through.
    always_comb begin
        CFG.offset_reference_select = offset_cal_config[acccs_pkg::BIT_OFFSET_REF]; // R1 R2
        CFG.background_calibration_enable = bg_control[acccs_pkg::BIT_BG_ENABLE]; // R14
        CFG.offset_average_depth =
            averaging_config[acccs_pkg::OFFSET_AVG_MSB:acccs_pkg::OFFSET_AVG_LSB]; // R4
        CFG.linearity_average_depth =
            averaging_config[acccs_pkg::LIN_AVG_MSB:acccs_pkg::LIN_AVG_LSB]; // R5
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------

    // There is no software write path here, so status writes have no effect.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            foreground_complete_flag <= 1'b0; // R15
            halted_flag <= 1'b0;
            status_code <= 3'h0;
        end else begin
            status_code <= ENGINE.code; // R6 R16
            if (ENGINE.fg_finished) begin
                foreground_complete_flag <= 1'b1; // R10
            end
            // Resume wins over a stop seen in the same cycle, since it is newer.
            if (ENGINE.resumed) begin
                halted_flag <= 1'b0; // R8
            end else if (ENGINE.bg_stopped) begin
                halted_flag <= 1'b1; // R7
            end else if (!CFG.background_calibration_enable && ENGINE.fg_finished) begin
                halted_flag <= 1'b1; // R9
            end
        end
    end

    // ------------------------------------------------------------------
    // Trigger pin synchroniser and source select
    // ------------------------------------------------------------------

    // Three flops; a change counts once the last two agree.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            trig_sync <= 3'h0;
            trig_clean <= 1'b0;
        end else begin
            trig_sync <= {trig_sync[1:0], HARDWARE_TRIGGER_INPUT};
            if (trig_sync[2] == trig_sync[1]) begin
                trig_clean <= trig_sync[2];
            end
        end
    end

    assign CAL_TRIGGER = calibration_pin_setup[acccs_pkg::BIT_TRIG_SRC]
        ? trig_clean : soft_trigger[acccs_pkg::BIT_SOFT_TRIG]; // R13

    // ------------------------------------------------------------------
    // Status pin
    // ------------------------------------------------------------------

    // The select field decodes straight into the pin source encoding.
    assign pin_sel = acccs_pkg::acccs_pin_sel_t'(
        calibration_pin_setup[acccs_pkg::PIN_SEL_MSB:acccs_pkg::PIN_SEL_LSB]);

    // Registered so the pin never glitches while the select changes.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            CALIBRATION_STATUS_PIN <= 1'b0;
        end else begin
            case (pin_sel)
                acccs_pkg::ACCCS_PIN_FG: CALIBRATION_STATUS_PIN <= foreground_complete_flag; // R12
                acccs_pkg::ACCCS_PIN_HALT: CALIBRATION_STATUS_PIN <= halted_flag; // R12
                acccs_pkg::ACCCS_PIN_ALARM: CALIBRATION_STATUS_PIN <= ALARM; // R12
                default: CALIBRATION_STATUS_PIN <= 1'b0; // R12
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------

    // Rising edges of done, halted and alarm are the events.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            fg_q <= 1'b0;
            halt_q <= 1'b0;
            alarm_q <= 1'b0;
        end else begin
            fg_q <= foreground_complete_flag;
            halt_q <= halted_flag;
            alarm_q <= ALARM;
        end
    end

    assign irq_event = {ALARM & ~alarm_q, halted_flag & ~halt_q, foreground_complete_flag & ~fg_q};

    // Write one to clear; a new event in the same cycle keeps its bit set.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            irq_status <= '0;
            irq_mask <= '0;
        end else begin
            if (wr_hit(ADDR, WR, acccs_pkg::OFS_IRQ_STATUS)) begin
                irq_status <= (irq_status & ~WDATA[acccs_pkg::IRQ_W-1:0]) | irq_event;
            end else begin
                irq_status <= irq_status | irq_event;
            end
            if (wr_hit(ADDR, WR, acccs_pkg::OFS_IRQ_MASK)) begin
                irq_mask <= WDATA[acccs_pkg::IRQ_W-1:0];
            end
        end
    end

    assign IRQ = |(irq_status & irq_mask);

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Unmapped offsets read as zero.
    always_comb begin
        next_rdata = acccs_pkg::RST_ZERO;
        if (ADDR == acccs_pkg::OFS_OFFSET_CAL_CONFIG) begin
            next_rdata = offset_cal_config;
        end else if (ADDR == acccs_pkg::OFS_AVERAGING_CONFIG) begin
            next_rdata = averaging_config;
        end else if (ADDR == acccs_pkg::OFS_CALIBRATION_STATUS) begin
            next_rdata[acccs_pkg::STAT_CODE_MSB:acccs_pkg::STAT_CODE_LSB] = status_code; // R6
            next_rdata[acccs_pkg::BIT_HALTED] = halted_flag; // R7
            next_rdata[acccs_pkg::BIT_FOREGROUND_COMPLETE_FLAG] = foreground_complete_flag; // R10
        end else if (ADDR == acccs_pkg::OFS_CALIBRATION_PIN_SETUP) begin
            next_rdata = calibration_pin_setup;
        end else if (ADDR == acccs_pkg::OFS_BG_CONTROL) begin
            next_rdata = bg_control;
        end else if (ADDR == acccs_pkg::OFS_SOFT_TRIGGER) begin
            next_rdata = soft_trigger;
        end else if (ADDR == acccs_pkg::OFS_IRQ_STATUS) begin
            next_rdata[acccs_pkg::IRQ_W-1:0] = irq_status;
        end else if (ADDR == acccs_pkg::OFS_IRQ_MASK) begin
            next_rdata[acccs_pkg::IRQ_W-1:0] = irq_mask;
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RDATA <= acccs_pkg::RST_ZERO;
        end else begin
            RDATA <= RD ? next_rdata : acccs_pkg::RST_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    // Flag, status, pin, trigger and setting checks; every check runs on CLK and pauses in reset.
    halt_clears_a: assert property (ENGINE.resumed |=> !halted_flag) // R8
        else $error("Halted flag not cleared on resume.");
    halt_sets_a: assert property (ENGINE.bg_stopped && !ENGINE.resumed |=> halted_flag) // R7
        else $error("Halted flag not set on stop.");
    fg_halt_a: assert property (!CFG.background_calibration_enable && ENGINE.fg_finished
        && !ENGINE.resumed |=> halted_flag) // R9
        else $error("Halted flag not set after foreground without background.");
    foreground_complete_flag_a: assert property (ENGINE.fg_finished |=> foreground_complete_flag) // R10
        else $error("Foreground flag not set.");
    status_read_a: assert property (RD && ADDR == acccs_pkg::OFS_CALIBRATION_STATUS |=>
        RDATA == {3'h0, $past(status_code), $past(halted_flag), $past(foreground_complete_flag)}) // R6
        else $error("Status read mismatch.");
    status_ro_a: assert property (WR && ADDR == acccs_pkg::OFS_CALIBRATION_STATUS
        && !ENGINE.fg_finished && !ENGINE.resumed && !ENGINE.bg_stopped
        |=> $stable(foreground_complete_flag) && $stable(halted_flag)) // R16
        else $error("Status changed by a write.");
    pin_low_a: assert property (pin_sel == acccs_pkg::ACCCS_PIN_LOW |=> !CALIBRATION_STATUS_PIN) // R12
        else $error("Status pin not low.");
    pin_fg_a: assert property (pin_sel == acccs_pkg::ACCCS_PIN_FG |=>
        CALIBRATION_STATUS_PIN == $past(foreground_complete_flag)) // R12
        else $error("Status pin not following done flag.");
    trig_hw_a: assert property (calibration_pin_setup[acccs_pkg::BIT_TRIG_SRC]
        && $past(trig_sync[2]) == $past(trig_sync[1])
        |-> CAL_TRIGGER == $past(trig_sync[2])) // R13
        else $error("Hardware trigger not taken from the synchronised pin.");
    trig_sw_a: assert property (!calibration_pin_setup[acccs_pkg::BIT_TRIG_SRC]
        |-> CAL_TRIGGER == soft_trigger[acccs_pkg::BIT_SOFT_TRIG]) // R13
        else $error("Software trigger not selected.");
    avg_depth_a: assert property (WR && ADDR == acccs_pkg::OFS_AVERAGING_CONFIG |=>
        CFG.offset_average_depth ==
            $past(WDATA[acccs_pkg::OFFSET_AVG_MSB:acccs_pkg::OFFSET_AVG_LSB])
        && CFG.linearity_average_depth ==
            $past(WDATA[acccs_pkg::LIN_AVG_MSB:acccs_pkg::LIN_AVG_LSB])) // R4 R5
        else $error("Averaging depth not written.");
    ref_sel_a: assert property (WR && ADDR == acccs_pkg::OFS_OFFSET_CAL_CONFIG |=>
        CFG.offset_reference_select == $past(WDATA[acccs_pkg::BIT_OFFSET_REF])) // R1 R2
        else $error("Reference select not written.");
    bg_en_a: assert property (WR && ADDR == acccs_pkg::OFS_BG_CONTROL |=>
        CFG.background_calibration_enable == $past(WDATA[acccs_pkg::BIT_BG_ENABLE])) // R14
        else $error("Background enable not written.");

    // Status pin follows each selected source one cycle late.
    pin_halt_a: assert property (pin_sel == acccs_pkg::ACCCS_PIN_HALT |=>
        CALIBRATION_STATUS_PIN == $past(halted_flag)) // R12
        else $error("Status pin not following halted flag.");
    pin_alarm_a: assert property (pin_sel == acccs_pkg::ACCCS_PIN_ALARM |=>
        CALIBRATION_STATUS_PIN == $past(ALARM)) // R12
        else $error("Status pin not following alarm.");
    pin_setup_a: assert property (WR && ADDR == acccs_pkg::OFS_CALIBRATION_PIN_SETUP |=>
        pin_sel == $past(WDATA[acccs_pkg::PIN_SEL_MSB:acccs_pkg::PIN_SEL_LSB])) // R12
        else $error("Pin source select not written.");

    // Flags hold until their own clear event.
    fg_sticky_a: assert property (foreground_complete_flag |=> foreground_complete_flag) // R10
        else $error("Foreground flag dropped without reset.");
    halt_hold_a: assert property (halted_flag && !ENGINE.resumed |=> halted_flag) // R7
        else $error("Halted flag dropped without resume.");

    // Interrupt bits: a new event survives a clear in the same cycle.
    irq_set_a: assert property (irq_event != '0 |=>
        (irq_status & $past(irq_event)) == $past(irq_event))
        else $error("Interrupt event lost.");
    irq_clear_a: assert property (WR && ADDR == acccs_pkg::OFS_IRQ_STATUS |=>
        (irq_status & $past(WDATA[acccs_pkg::IRQ_W-1:0]) & ~$past(irq_event)) == '0)
        else $error("Interrupt bit not cleared by a written one.");
    mask_write_a: assert property (WR && ADDR == acccs_pkg::OFS_IRQ_MASK |=>
        irq_mask == $past(WDATA[acccs_pkg::IRQ_W-1:0]))
        else $error("Interrupt mask not written.");

    // Read data falls back to zero outside the answer cycle; a stale byte would
    // otherwise look like a second answer to software.
    rdata_idle_a: assert property (!RD |=> RDATA == acccs_pkg::RST_ZERO)
        else $error("Read data not zero outside the answer cycle.");

    // Main scenarios worth seeing at least once.
    fg_seen_c: cover property (ENGINE.fg_finished ##1 foreground_complete_flag);
    halt_cycle_c: cover property (ENGINE.bg_stopped ##[1:20] ENGINE.resumed);
    irq_c: cover property (IRQ ##1 WR && ADDR == acccs_pkg::OFS_IRQ_STATUS);
    pin_alarm_c: cover property (pin_sel == acccs_pkg::ACCCS_PIN_ALARM && ALARM);
    trig_hw_c: cover property (calibration_pin_setup[acccs_pkg::BIT_TRIG_SRC] && trig_clean);

endmodule

`default_nettype wire

// [rtl/acccs_pkg.sv]
// Package for the calibration configuration and status register bank.
// Assumes a single device clock domain and an 8-bit plain register port.
package acccs_pkg;

    // ------------------------------------------------------------------
    // Register offsets, widths and reset values
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_OFFSET_CAL_CONFIG = 8'h65;
    localparam logic [7:0] OFS_BG_CONTROL = 8'h66;
    localparam logic [7:0] OFS_AVERAGING_CONFIG = 8'h68;
    localparam logic [7:0] OFS_CALIBRATION_STATUS = 8'h6A;
    localparam logic [7:0] OFS_CALIBRATION_PIN_SETUP = 8'h6B;
    localparam logic [7:0] OFS_SOFT_TRIGGER = 8'h6C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h70;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h71;
    localparam logic [7:0] RST_OFFSET_CAL_CONFIG = 8'h01;
    localparam logic [7:0] RST_AVERAGING_CONFIG = 8'h61;
    localparam logic [7:0] RST_CALIBRATION_PIN_SETUP = 8'h00;
    localparam logic [7:0] RST_BG_CONTROL = 8'h00;
    localparam logic [7:0] RST_SOFT_TRIGGER = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_OFFSET_REF = 2;
    localparam int BIT_BG_ENABLE = 0;
    localparam int BIT_SOFT_TRIG = 0;
    localparam int BIT_TRIG_SRC = 0;
    localparam int BIT_FOREGROUND_COMPLETE_FLAG = 0;
    localparam int BIT_HALTED = 1;
    localparam int STAT_CODE_LSB = 2;
    localparam int STAT_CODE_MSB = 4;
    localparam int OFFSET_AVG_LSB = 4;
    localparam int OFFSET_AVG_MSB = 6;
    localparam int LIN_AVG_LSB = 0;
    localparam int LIN_AVG_MSB = 2;
    localparam int PIN_SEL_LSB = 1;
    localparam int PIN_SEL_MSB = 2;
    localparam int IRQ_W = 3;
    localparam int IRQ_FG = 0;
    localparam int IRQ_HALT = 1;
    localparam int IRQ_ALARM = 2;

    // ------------------------------------------------------------------
    // Status pin source encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACCCS_PIN_FG = 2'b00,
        ACCCS_PIN_HALT = 2'b01,
        ACCCS_PIN_ALARM = 2'b10,
        ACCCS_PIN_LOW = 2'b11
    } acccs_pin_sel_t;

    // Settings handed to the calibration engine.
    typedef struct packed {
        logic offset_reference_select;
        logic background_calibration_enable;
        logic [2:0] offset_average_depth;
        logic [2:0] linearity_average_depth;
    } acccs_cfg_t;

    // Progress reported by the calibration engine.
    typedef struct packed {
        logic fg_finished;
        logic bg_stopped;
        logic resumed;
        logic [2:0] code;
    } acccs_engine_t;

endpackage

// [test/acccs_regs_bench.sv]
// Self-checking bench for the calibration register bank.
// Assumes the package and acccs_regs are compiled first; one 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module acccs_regs_bench;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk;
    logic nrst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    acccs_pkg::acccs_engine_t eng;
    acccs_pkg::acccs_cfg_t cfg;
    logic alarm;
    logic cal_trig;
    logic hw_trig;
    logic stat_pin;
    logic irq;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    int fails;
    int tests_run;
    int cycles;
    logic [31:0] seed;
    logic [7:0] r8;
    logic [2:0] code;
    logic pb;
    localparam logic [7:0] RST_ADDR [8] = '{8'h65, 8'h66, 8'h68, 8'h6A, 8'h6B, 8'h6C, 8'h71, 8'h50};
    localparam logic [7:0] RST_VAL [8] = '{8'h01, 8'h00, 8'h61, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};

    acccs_regs acccs_regs_inst (
        .CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .ENGINE(eng), .ALARM(alarm), .CFG(cfg), .CAL_TRIGGER(cal_trig),
        .HARDWARE_TRIGGER_INPUT(hw_trig), .CALIBRATION_STATUS_PIN(stat_pin), .IRQ(irq)
    );

    // Free-running clock of 10 ns.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        y = y ^ (y << 5);
        return y;
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("Checks run %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // The expected byte is queued at the strobe; the watcher pops it later.
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic pulse(input logic f, input logic s, input logic r);
        @(posedge clk);
        eng.fg_finished <= f;
        eng.bg_stopped <= s;
        eng.resumed <= r;
        @(posedge clk);
        eng.fg_finished <= 1'b0;
        eng.bg_stopped <= 1'b0;
        eng.resumed <= 1'b0;
    endtask

    task automatic check_reset;
        for (int i = 0; i < 8; i++) begin
            rd_reg(RST_ADDR[i], RST_VAL[i]);
        end
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle.
    always @(negedge clk) begin
        if (rd_seen) begin
            chk("RDATA", exp_q.pop_front(), rdata);
        end
        rd_seen = rd;
    end

    // Hang guard; the full sequence needs well under a thousand cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            report_and_stop;
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        eng = '0;
        alarm = 1'b0;
        hw_trig = 1'b0;
        fails = 0;
        tests_run = 0;
        seed = 32'h47;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("CFG", 8'h31, cfg);
        chk("CAL_TRIGGER", 8'h01, {7'h00, cal_trig});
        check_reset();
        // Random depths, reserved bits kept at zero.
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            r8 = seed[7:0] & 8'h77;
            wr_reg(8'h68, r8);
            rd_reg(8'h68, r8);
            #1;
            chk("CFG", {2'b00, r8[6:4], r8[2:0]}, cfg);
        end
        wr_reg(8'h66, 8'h01);
        wr_reg(8'h65, 8'h05);
        rd_reg(8'h65, 8'h05);
        #1;
        chk("CFG", {2'b11, r8[6:4], r8[2:0]}, cfg);
        wr_reg(8'h65, 8'h01);
        wr_reg(8'h66, 8'h00);
        #1;
        chk("CFG", {2'b00, r8[6:4], r8[2:0]}, cfg);
        // Status flags and code, background disabled first.
        seed = xs(seed);
        code = seed[2:0];
        @(posedge clk);
        eng.code <= code;
        rd_reg(8'h6A, {3'b000, code, 2'b00});
        pulse(1'b1, 1'b0, 1'b0);
        rd_reg(8'h6A, {3'b000, code, 2'b11});
        pulse(1'b0, 1'b0, 1'b1);
        rd_reg(8'h6A, {3'b000, code, 2'b01});
        wr_reg(8'h66, 8'h01);
        pulse(1'b0, 1'b1, 1'b0);
        rd_reg(8'h6A, {3'b000, code, 2'b11});
        wr_reg(8'h6A, 8'hFF);
        rd_reg(8'h6A, {3'b000, code, 2'b11});
        // Every pin source with halted and alarm set apart.
        for (int h = 0; h < 2; h++) begin
            pulse(1'b0, h[0], ~h[0]);
            @(posedge clk);
            alarm <= ~h[0];
            for (int s = 0; s < 4; s++) begin
                wr_reg(8'h6B, {5'h00, s[1:0], 1'b0});
                hold(3);
                pb = (s == 0) ? 1'b1 : (s == 1) ? h[0] : (s == 2) ? ~h[0] : 1'b0;
                chk("STATUS_PIN", {7'h00, pb}, {7'h00, stat_pin});
            end
        end
        // Trigger source: software bit, then the synchronised pin.
        wr_reg(8'h6C, 8'h00);
        hold(1);
        chk("CAL_TRIGGER", 8'h00, {7'h00, cal_trig});
        wr_reg(8'h6B, 8'h01);
        @(posedge clk);
        hw_trig <= 1'b1;
        hold(8);
        chk("CAL_TRIGGER", 8'h01, {7'h00, cal_trig});
        wr_reg(8'h6C, 8'h01);
        @(posedge clk);
        hw_trig <= 1'b0;
        hold(8);
        chk("CAL_TRIGGER", 8'h00, {7'h00, cal_trig});
        // Interrupt: sticky status, mask, write-one-to-clear.
        rd_reg(8'h70, 8'h07);
        hold(1);
        chk("IRQ", 8'h00, {7'h00, irq});
        wr_reg(8'h71, 8'h01);
        hold(1);
        chk("IRQ", 8'h01, {7'h00, irq});
        wr_reg(8'h70, 8'h01);
        hold(1);
        chk("IRQ", 8'h00, {7'h00, irq});
        rd_reg(8'h70, 8'h06);
        wr_reg(8'h71, 8'h06);
        hold(1);
        chk("IRQ", 8'h01, {7'h00, irq});
        wr_reg(8'h70, 8'h06);
        hold(1);
        chk("IRQ", 8'h00, {7'h00, irq});
        // Second reset in mid-run restores every register.
        @(posedge clk);
        eng.code <= 3'h0;
        nrst <= 1'b0;
        hold(2);
        chk("CFG", 8'h31, cfg);
        chk("STATUS_PIN", 8'h00, {7'h00, stat_pin});
        @(posedge clk);
        nrst <= 1'b1;
        check_reset();
        hold(3);
        report_and_stop();
    end

endmodule

`default_nettype wire
